//--- dsetr_consts.svh
// register offsets, field positions and sizes of the discrete status and event tag bank
`ifndef DSETR_CONSTS_SVH
`define DSETR_CONSTS_SVH
`define DSETR_OFF_LVL_LO12     12'h000
`define DSETR_OFF_LVL_HI12     12'h004
`define DSETR_OFF_LVL_LO16     12'h008
`define DSETR_OFF_LVL_HI8      12'h00C
`define DSETR_OFF_LVL_COMB     12'h010
`define DSETR_OFF_EV_SNAP      12'h014
`define DSETR_OFF_EV_HM        12'h018
`define DSETR_OFF_EV_SEC       12'h01C
`define DSETR_OFF_EV_MICRO     12'h020
`define DSETR_OFF_EV_T48_LO    12'h024
`define DSETR_OFF_EV_T48_HI    12'h028
`define DSETR_OFF_EV_FILL      12'h02C
`define DSETR_OFF_IRQ_STAT     12'h030
`define DSETR_OFF_IRQ_MASK     12'h034
`define DSETR_ADDR_W           12
`define DSETR_FIFO_DEPTH       8192
`define DSETR_NUM_INPUTS       24
`define DSETR_NUM_PARTS        4
`define DSETR_IRQ_W            3
`define DSETR_IRQ_OVF          0
`define DSETR_IRQ_EVT          1
`define DSETR_IRQ_EMPTY_RD     2
`define DSETR_RESP_OKAY        2'h0
`define DSETR_RESP_SLVERR      2'h2
`endif

//--- dsetr_pkg.sv
// types shared by the discrete status and event tag bank
package dsetr_pkg;
  // one time-tagged event record, 64 bits, most significant field first
  typedef struct packed {
    logic [15:0] hours_minutes;
    logic [15:0] seconds;
    logic [15:0] microseconds;
    logic [15:0] snapshot;
  } dsetr_record_s;

  typedef enum logic [2:0] {
    DSETR_RD_IDLE = 3'h1,
    DSETR_RD_DATA = 3'h2,
    DSETR_RD_RESP = 3'h4
  } dsetr_rd_e;
endpackage

//--- dsetr_event_fifo.sv
// event record fifo: flip-flop storage, index addressed, with fill count
`timescale 1ns/100ps
`include "dsetr_consts.svh"
module dsetr_event_fifo #(
  parameter int DEPTH = `DSETR_FIFO_DEPTH
) (
  input  wire logic                  sys_clk,    // system clock
  input  wire logic                  rst_n,      // async reset, active low
  input  wire logic                  wr_valid,   // record offered
  input  wire dsetr_pkg::dsetr_record_s wr_data, // record to store
  output logic                       wr_ready,   // room for a record
  output logic                       rd_valid,   // head record present
  output dsetr_pkg::dsetr_record_s   rd_data,    // head record
  input  wire logic                  rd_ready,   // pop head
  output logic [$clog2(DEPTH):0]     fill        // records held
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
  end

  dsetr_pkg::dsetr_record_s mem_ff [DEPTH];
  logic [AW:0]              wptr_ff;
  logic [AW:0]              rptr_ff;
  wire                      do_wr = wr_valid && wr_ready;
  wire                      do_rd = rd_valid && rd_ready;

  assign fill     = wptr_ff - rptr_ff;
  assign wr_ready = fill != (AW + 1)'(DEPTH);
  assign rd_valid = fill != '0;
  assign rd_data  = mem_ff[rptr_ff[AW-1:0]];

  always_ff @(posedge sys_clk) begin
    if (do_wr) begin
      mem_ff[wptr_ff[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
    end else begin
      if (do_wr) wptr_ff <= wptr_ff + 1'b1;
      if (do_rd) rptr_ff <= rptr_ff + 1'b1;
    end
  end
endmodule

//--- dsetr_regs.sv
// discrete input status views and time-tagged event record registers, axi4-lite slave
// Summary of operation
// - all 24 input levels readable as 16+8 bit or 12+12 bit registers
// - lower twelve view: bits 15:4 carry inputs 11:0, bits 3:0 zero
// - upper twelve view: bits 15:4 carry inputs 23:12, bits 3:0 zero
// - upper eight view: bits 15:8 carry inputs 23:16, low byte zero
// - lower sixteen view: bits 0..15 carry inputs 0..15 ascending
// - every level view comes from one sampled copy, so all agree
// - event snapshot holds inputs 8..23 of the current record
// - with fifo empty, event registers repeat the last record read
// - event hours/minutes register belongs to the current snapshot
// - event seconds/centiseconds register belongs to the current snapshot
// - event microseconds register belongs to the current snapshot
// - event record is one 64-bit quantity; four parts come from one event
// - 48-bit combined time equals hours, seconds and micro fields concatenated
// - combined level word: inputs 0..15 at bits 0..15, 16..23 at 24..31
// - each armed trigger writes one 64-bit time plus snapshot record
// - time fields are bcd, up to 23:59:59.999999
// - each record buffer holds 8192 entries; overflow loses records
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "dsetr_consts.svh"
module dsetr_regs #(
  parameter int FIFO_DEPTH = `DSETR_FIFO_DEPTH
) (
  input  wire logic        sys_clk,       // 50 MHz system clock
  input  wire logic        rst_n,         // async reset, active low
  input  wire logic [23:0] din_pins,      // discrete input levels, asynchronous
  input  wire logic        trig_valid,    // armed input changed, one-cycle pulse
  input  wire logic [47:0] trig_time_bcd, // bcd time of day at the trigger
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [11:0] s_axi_awaddr,  // write byte address
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // write byte enables
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  output logic [1:0]       s_axi_bresp,   // write response
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  input  wire logic [11:0] s_axi_araddr,  // read byte address
  output logic             s_axi_rvalid,  // read data valid
  input  wire logic        s_axi_rready,  // read data ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  output logic             irq            // level interrupt, active high
);
  localparam int FW = $clog2(FIFO_DEPTH);

  initial begin
    if (FIFO_DEPTH < 2) $error("fifo depth too small");
  end

  // input synchroniser; first stage read only by the second
  logic [23:0] din_s1_ff;
  logic [23:0] din_s2_ff;
  logic [23:0] lvl_ff;

  // event path
  dsetr_pkg::dsetr_record_s trig_rec;
  dsetr_pkg::dsetr_record_s head_rec;
  dsetr_pkg::dsetr_record_s cur_rec_ff;
  logic                     fifo_wr_ready;
  logic                     fifo_rd_valid;
  logic [FW:0]              fifo_fill;
  logic [3:0]               parts_read_ff;
  logic                     rec_loaded_ff;
  logic                     pop;

  // interrupt registers
  logic [`DSETR_IRQ_W-1:0]  irq_stat_ff;
  logic [`DSETR_IRQ_W-1:0]  irq_mask_ff;
  logic                     irq_ff;

  // write channel
  logic                     aw_held_ff;
  logic                     w_held_ff;
  logic [11:0]              awaddr_ff;
  logic [31:0]              wdata_ff;
  logic [3:0]               wstrb_ff;
  logic                     bvalid_ff;
  logic [1:0]               bresp_ff;

  // read channel
  dsetr_pkg::dsetr_rd_e     rd_st_ff;
  logic [11:0]              araddr_ff;
  logic [31:0]              rdata_ff;
  logic [1:0]               rresp_ff;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      din_s1_ff <= 24'h000000;
      din_s2_ff <= 24'h000000;
      lvl_ff    <= 24'h000000;
    end else begin
      din_s1_ff <= din_pins;
      din_s2_ff <= din_s1_ff;
      lvl_ff    <= din_s2_ff;
    end
  end

  // level views, all cut from lvl_ff so a single sample feeds every layout
  wire [15:0] v_lo12 = {lvl_ff[11:0], 4'h0};
  wire [15:0] v_hi12 = {lvl_ff[23:12], 4'h0};
  wire [15:0] v_hi8  = {lvl_ff[23:16], 8'h00};
  wire [15:0] v_lo16 = lvl_ff[15:0];
  wire [31:0] v_comb = {lvl_ff[23:16], 8'h00, lvl_ff[15:0]};

  // record written per trigger: time in bcd, snapshot after the change
  assign trig_rec = {trig_time_bcd, din_s2_ff[23:8]};

  dsetr_event_fifo #(
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .wr_valid (trig_valid),
    .wr_data  (trig_rec),
    .wr_ready (fifo_wr_ready),
    .rd_valid (fifo_rd_valid),
    .rd_data  (head_rec),
    .rd_ready (pop),
    .fill     (fifo_fill)
  );

  // read decode
  wire rd_take   = s_axi_arvalid && s_axi_arready;
  wire [11:0] ra = s_axi_araddr;
  wire hit_snap  = ra == `DSETR_OFF_EV_SNAP;
  wire hit_hm    = ra == `DSETR_OFF_EV_HM;
  wire hit_sec   = ra == `DSETR_OFF_EV_SEC;
  wire hit_mic   = ra == `DSETR_OFF_EV_MICRO;
  wire hit_t48l  = ra == `DSETR_OFF_EV_T48_LO;
  wire hit_t48h  = ra == `DSETR_OFF_EV_T48_HI;
  wire [47:0] t48 = {cur_rec_ff.hours_minutes, cur_rec_ff.seconds,
                     cur_rec_ff.microseconds};

  // each event-part read marks one of the four parts; combined time reads cover time parts
  wire [3:0] part_hit = rd_take ? {hit_hm || hit_t48h, hit_sec || hit_t48l,
                                   hit_mic || hit_t48l, hit_snap} : 4'h0;
  wire [3:0] parts_nxt = parts_read_ff | part_hit;
  // pop only once every part of the held record was read, new one loads next cycle
  wire need_load = !rec_loaded_ff || (parts_nxt == 4'hF);
  assign pop     = fifo_rd_valid && need_load && !rd_take;
  wire empty_rd  = rd_take && (|part_hit) && !fifo_rd_valid && (parts_nxt == 4'hF);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_rec_ff    <= '0;
      parts_read_ff <= 4'h0;
      rec_loaded_ff <= 1'b0;
    end else if (pop) begin
      cur_rec_ff    <= head_rec;
      parts_read_ff <= 4'h0;
      rec_loaded_ff <= 1'b1;
    end else begin
      parts_read_ff <= parts_nxt;
    end
  end

  // read data mux
  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    case (ra)
      `DSETR_OFF_LVL_LO12:   rd_mux = {16'h0000, v_lo12};
      `DSETR_OFF_LVL_HI12:   rd_mux = {16'h0000, v_hi12};
      `DSETR_OFF_LVL_LO16:   rd_mux = {16'h0000, v_lo16};
      `DSETR_OFF_LVL_HI8:    rd_mux = {16'h0000, v_hi8};
      `DSETR_OFF_LVL_COMB:   rd_mux = v_comb;
      `DSETR_OFF_EV_SNAP:    rd_mux = {16'h0000, cur_rec_ff.snapshot};
      `DSETR_OFF_EV_HM:      rd_mux = {16'h0000, cur_rec_ff.hours_minutes};
      `DSETR_OFF_EV_SEC:     rd_mux = {16'h0000, cur_rec_ff.seconds};
      `DSETR_OFF_EV_MICRO:   rd_mux = {16'h0000, cur_rec_ff.microseconds};
      `DSETR_OFF_EV_T48_LO:  rd_mux = t48[31:0];
      `DSETR_OFF_EV_T48_HI:  rd_mux = {16'h0000, t48[47:32]};
      `DSETR_OFF_EV_FILL:    rd_mux = 32'(fifo_fill);
      `DSETR_OFF_IRQ_STAT:   rd_mux = 32'(irq_stat_ff);
      `DSETR_OFF_IRQ_MASK:   rd_mux = 32'(irq_mask_ff);
      default:               rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = rd_st_ff == dsetr_pkg::DSETR_RD_IDLE;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_st_ff  <= dsetr_pkg::DSETR_RD_IDLE;
      araddr_ff <= 12'h000;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= `DSETR_RESP_OKAY;
    end else begin
      case (rd_st_ff)
        dsetr_pkg::DSETR_RD_IDLE: begin
          if (rd_take) begin
            araddr_ff <= ra;
            rdata_ff  <= rd_mux;
            rresp_ff  <= rd_hit ? `DSETR_RESP_OKAY : `DSETR_RESP_SLVERR;
            rd_st_ff  <= dsetr_pkg::DSETR_RD_RESP;
          end
        end
        dsetr_pkg::DSETR_RD_RESP: begin
          if (s_axi_rready) rd_st_ff <= dsetr_pkg::DSETR_RD_IDLE;
        end
        default: rd_st_ff <= dsetr_pkg::DSETR_RD_IDLE;
      endcase
    end
  end

  assign s_axi_rvalid = rd_st_ff == dsetr_pkg::DSETR_RD_RESP;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

  // write channel: address and data taken in either order, answered one cycle after both
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready  = !w_held_ff && !bvalid_ff;
  wire aw_now    = aw_held_ff || s_axi_awvalid;
  wire w_now     = w_held_ff || s_axi_wvalid;
  wire [11:0] wa = aw_held_ff ? awaddr_ff : s_axi_awaddr;
  wire [31:0] wd = w_held_ff ? wdata_ff : s_axi_wdata;
  wire [3:0]  ws = w_held_ff ? wstrb_ff : s_axi_wstrb;
  wire wr_do     = aw_now && w_now && !bvalid_ff;
  wire wr_stat   = wr_do && wa == `DSETR_OFF_IRQ_STAT && ws[0];
  wire wr_mask   = wr_do && wa == `DSETR_OFF_IRQ_MASK && ws[0];
  wire wr_ok     = wa == `DSETR_OFF_IRQ_STAT || wa == `DSETR_OFF_IRQ_MASK;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awaddr_ff  <= 12'h000;
      wdata_ff   <= 32'h00000000;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `DSETR_RESP_OKAY;
    end else begin
      if (wr_do) begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= wr_ok ? `DSETR_RESP_OKAY : `DSETR_RESP_SLVERR;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_held_ff <= 1'b1;
          awaddr_ff  <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_held_ff <= 1'b1;
          wdata_ff  <= s_axi_wdata;
          wstrb_ff  <= s_axi_wstrb;
        end
        if (bvalid_ff && s_axi_bready) bvalid_ff <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  // interrupt: overflow loses a record, so it is flagged; set wins over clear
  wire [`DSETR_IRQ_W-1:0] ev_set;
  assign ev_set[`DSETR_IRQ_OVF]     = trig_valid && !fifo_wr_ready;
  assign ev_set[`DSETR_IRQ_EVT]     = trig_valid && fifo_wr_ready;
  assign ev_set[`DSETR_IRQ_EMPTY_RD] = empty_rd;
  wire [`DSETR_IRQ_W-1:0] stat_clr = wr_stat ? wd[`DSETR_IRQ_W-1:0] : '0;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
      irq_ff      <= 1'b0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~stat_clr) | ev_set;
      if (wr_mask) irq_mask_ff <= wd[`DSETR_IRQ_W-1:0];
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  assign irq = irq_ff;

  // assertions
  property p_lvl_views;
    @(posedge sys_clk) disable iff (!rst_n)
      v_comb[15:0] == v_lo16 && v_comb[31:24] == v_hi8[15:8] && v_hi12[15:8] == v_comb[31:24]
      && v_hi12[7:4] == v_comb[15:12] && v_lo12[15:4] == v_comb[11:0] && v_lo12[3:0] == 4'h0;
  endproperty
  a_lvl_views: assert property (p_lvl_views) else $error("level views disagree");

  property p_comb_gap;
    @(posedge sys_clk) disable iff (!rst_n) v_comb[23:16] == 8'h00;
  endproperty
  a_comb_gap: assert property (p_comb_gap) else $error("combined gap not zero");

  property p_sync_lat;
    // the pipe is only full three edges after release; earlier it still holds reset zeros
    @(posedge sys_clk) disable iff (!rst_n) $past(rst_n, 3) |-> lvl_ff == $past(din_pins, 3);
  endproperty
  a_sync_lat: assert property (p_sync_lat) else $error("level latency wrong");

  property p_hold_empty;
    @(posedge sys_clk) disable iff (!rst_n) !fifo_rd_valid |=> $stable(cur_rec_ff);
  endproperty
  a_hold_empty: assert property (p_hold_empty) else $error("record changed while empty");

  property p_no_early_pop;
    @(posedge sys_clk) disable iff (!rst_n)
      rec_loaded_ff && parts_read_ff != 4'hF && !(|part_hit) |=> $stable(cur_rec_ff);
  endproperty
  a_no_early_pop: assert property (p_no_early_pop) else $error("record popped early");

  property p_load_head;
    @(posedge sys_clk) disable iff (!rst_n) pop |=> cur_rec_ff == $past(head_rec);
  endproperty
  a_load_head: assert property (p_load_head) else $error("record not from head");

  property p_t48;
    @(posedge sys_clk) disable iff (!rst_n)
      rd_take && hit_t48l |=> s_axi_rdata == {$past(cur_rec_ff.seconds),
                                              $past(cur_rec_ff.microseconds)};
  endproperty
  a_t48: assert property (p_t48) else $error("combined time mismatch");

  property p_hm_read;
    @(posedge sys_clk) disable iff (!rst_n)
      rd_take && hit_hm |=> s_axi_rdata == {16'h0000, $past(cur_rec_ff.hours_minutes)};
  endproperty
  a_hm_read: assert property (p_hm_read) else $error("hours minutes read wrong");

  // a clear landing with an event must not swallow it
  property p_set_wins;
    @(posedge sys_clk) disable iff (!rst_n)
      |ev_set |=> (irq_stat_ff & $past(ev_set)) == $past(ev_set);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event flag lost to clear");

  property p_ovf_flag;
    @(posedge sys_clk) disable iff (!rst_n)
      trig_valid && !fifo_wr_ready |=> irq_stat_ff[`DSETR_IRQ_OVF];
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow not flagged");

  sequence s_push;
    trig_valid && fifo_wr_ready && fifo_fill == '0 && rec_loaded_ff == 1'b0 && !rd_take;
  endsequence
  property p_first_load;
    @(posedge sys_clk) disable iff (!rst_n)
      s_push ##1 !rd_take |=> cur_rec_ff.snapshot == $past(din_s2_ff[23:8], 2); 
  endproperty
  a_first_load: assert property (p_first_load) else $error("snapshot wrong");
endmodule

//--- dsetr_regs_test.sv
// self-checking bench for the discrete status and event tag register bank
`timescale 1ns/100ps
`include "dsetr_consts.svh"
module dsetr_regs_test;
  localparam int DEPTH = 8;
  localparam int LIMIT = 20000;
  typedef struct packed {
    logic [23:0] din;
    logic [31:0] comb;
  } dsetr_row_s;

  logic        sys_clk       = 1'b0;
  logic        rst_n         = 1'b0;
  logic [23:0] din_pins      = 24'h000000;
  logic        trig_valid    = 1'b0;
  logic [47:0] trig_time_bcd = 48'h0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [11:0] s_axi_awaddr  = 12'h000;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_wready;
  logic [31:0] s_axi_wdata   = 32'h0;
  logic [3:0]  s_axi_wstrb   = 4'hF;
  logic        s_axi_bvalid;
  logic        s_axi_bready  = 1'b0;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [11:0] s_axi_araddr  = 12'h000;
  logic        s_axi_rvalid;
  logic        s_axi_rready  = 1'b0;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        irq;
  int          fails         = 0;
  int          cmp_count     = 0;
  int          cyc           = 0;
  logic [1:0]  resp;
  logic [31:0] data;
  logic [47:0] t [3] = '{48'h2359_5999_9999, 48'h0000_0000_0001, 48'h1230_4507_0042};
  dsetr_row_s  rows [4] = '{'{24'h000000, 32'h00000000}, '{24'hFFFFFF, 32'hFF00FFFF},
                            '{24'hA5C3F0, 32'hA500C3F0}, '{24'h5A0F81, 32'h5A000F81}};

  dsetr_regs #(.FIFO_DEPTH(DEPTH)) i_dsetr_regs (
    .sys_clk(sys_clk), .rst_n(rst_n), .din_pins(din_pins), .trig_valid(trig_valid),
    .trig_time_bcd(trig_time_bcd), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .irq(irq)
  );

  always #10 sys_clk = ~sys_clk;

  // a hung handshake ends the run here rather than stalling forever
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fails = fails + 1;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // each task ends one edge after release so the next one never drives twice in a step
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw_done;
    bit w_done;
    aw_done = 0;
    w_done = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge sys_clk);
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge sys_clk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge sys_clk);
    while (s_axi_arready !== 1'b1) @(posedge sys_clk);
    s_axi_arvalid <= 1'b0;
    @(posedge sys_clk);
    while (s_axi_rvalid !== 1'b1) @(posedge sys_clk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk({name, " resp"}, {30'h0, r}, {30'h0, `DSETR_RESP_OKAY});
    chk(name, d, exp);
  endtask

  task automatic push(input logic [47:0] tm);
    trig_time_bcd <= tm;
    trig_valid <= 1'b1;
    @(posedge sys_clk);
    trig_valid <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
  endtask

  initial begin
    do_reset();
    rd_chk("snapshot after reset", `DSETR_OFF_EV_SNAP, 32'h0);
    for (int i = 0; i < 4; i++) begin
      din_pins <= rows[i].din;
      repeat (4) @(posedge sys_clk);
      rd_chk("combined", `DSETR_OFF_LVL_COMB, rows[i].comb);
      rd_chk("lower16", `DSETR_OFF_LVL_LO16, {16'h0, rows[i].comb[15:0]});
      rd_chk("upper8", `DSETR_OFF_LVL_HI8, {16'h0, rows[i].comb[31:24], 8'h00});
      rd_chk("lower12", `DSETR_OFF_LVL_LO12, {16'h0, rows[i].din[11:0], 4'h0});
      rd_chk("upper12", `DSETR_OFF_LVL_HI12, {16'h0, rows[i].din[23:12], 4'h0});
    end
    // refused accesses
    axi_rd(12'h03C, data, resp);
    chk("unmapped resp", {30'h0, resp}, {30'h0, `DSETR_RESP_SLVERR});
    chk("unmapped data", data, 32'h0);
    axi_wr(`DSETR_OFF_LVL_LO12, 32'hFFFFFFFF, resp);
    chk("ro write resp", {30'h0, resp}, {30'h0, `DSETR_RESP_SLVERR});
    rd_chk("lower12 kept", `DSETR_OFF_LVL_LO12, {16'h0, rows[3].din[11:0], 4'h0});
    // three events, pushed masked, then irq raised and cleared
    din_pins <= 24'h3C5A69;
    repeat (4) @(posedge sys_clk);
    axi_wr(`DSETR_OFF_IRQ_STAT, 32'h7, resp);
    for (int i = 0; i < 3; i++) push(t[i]);
    repeat (3) @(posedge sys_clk);
    chk("irq masked", {31'h0, irq}, 32'h0);
    rd_chk("stat pushed", `DSETR_OFF_IRQ_STAT, 32'h2);
    rd_chk("fill", `DSETR_OFF_EV_FILL, 32'h2);
    axi_wr(`DSETR_OFF_IRQ_MASK, 32'h2, resp);
    @(posedge sys_clk);
    chk("irq unmasked", {31'h0, irq}, 32'h1);
    rd_chk("mask", `DSETR_OFF_IRQ_MASK, 32'h2);
    s_axi_wstrb <= 4'h0;
    axi_wr(`DSETR_OFF_IRQ_MASK, 32'h0, resp);
    s_axi_wstrb <= 4'hF;
    rd_chk("mask kept", `DSETR_OFF_IRQ_MASK, 32'h2);
    axi_wr(`DSETR_OFF_IRQ_STAT, 32'h2, resp);
    @(posedge sys_clk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    rd_chk("snap0", `DSETR_OFF_EV_SNAP, 32'h3C5A);
    rd_chk("hm0", `DSETR_OFF_EV_HM, {16'h0, t[0][47:32]});
    rd_chk("sec0", `DSETR_OFF_EV_SEC, {16'h0, t[0][31:16]});
    rd_chk("micro0", `DSETR_OFF_EV_MICRO, {16'h0, t[0][15:0]});
    repeat (3) @(posedge sys_clk);
    rd_chk("snap1", `DSETR_OFF_EV_SNAP, 32'h3C5A);
    rd_chk("t48 hi1", `DSETR_OFF_EV_T48_HI, {16'h0, t[1][47:32]});
    rd_chk("t48 lo1", `DSETR_OFF_EV_T48_LO, t[1][31:0]);
    repeat (3) @(posedge sys_clk);
    rd_chk("snap2", `DSETR_OFF_EV_SNAP, 32'h3C5A);
    rd_chk("hm2", `DSETR_OFF_EV_HM, {16'h0, t[2][47:32]});
    rd_chk("sec2", `DSETR_OFF_EV_SEC, {16'h0, t[2][31:16]});
    rd_chk("micro2", `DSETR_OFF_EV_MICRO, {16'h0, t[2][15:0]});
    repeat (3) @(posedge sys_clk);
    rd_chk("snap repeat", `DSETR_OFF_EV_SNAP, 32'h3C5A);
    rd_chk("t48 repeat", `DSETR_OFF_EV_T48_LO, t[2][31:0]);
    rd_chk("stat empty read", `DSETR_OFF_IRQ_STAT, 32'h4);
    // overflow: head plus DEPTH held, the last push is lost
    axi_wr(`DSETR_OFF_IRQ_STAT, 32'h7, resp);
    axi_wr(`DSETR_OFF_IRQ_MASK, 32'h1, resp);
    for (int i = 0; i < DEPTH + 2; i++) push({16'h0101, 16'h0202, 16'(i)});
    repeat (3) @(posedge sys_clk);
    rd_chk("fill full", `DSETR_OFF_EV_FILL, 32'(DEPTH));
    rd_chk("stat ovf", `DSETR_OFF_IRQ_STAT, 32'h3);
    chk("irq ovf", {31'h0, irq}, 32'h1);
    for (int i = 0; i <= DEPTH; i++) begin
      rd_chk("drain snap", `DSETR_OFF_EV_SNAP, 32'h3C5A);
      rd_chk("drain hm", `DSETR_OFF_EV_HM, 32'h0101);
      rd_chk("drain t48", `DSETR_OFF_EV_T48_LO, {16'h0202, 16'(i)});
      repeat (3) @(posedge sys_clk);
    end
    rd_chk("fill empty", `DSETR_OFF_EV_FILL, 32'h0);
    // second reset in mid-run clears record, flags and mask
    do_reset();
    chk("irq reset", {31'h0, irq}, 32'h0);
    rd_chk("snap reset", `DSETR_OFF_EV_SNAP, 32'h0);
    rd_chk("stat reset", `DSETR_OFF_IRQ_STAT, 32'h0);
    rd_chk("mask reset", `DSETR_OFF_IRQ_MASK, 32'h0);
    rd_chk("fill reset", `DSETR_OFF_EV_FILL, 32'h0);
    tally_and_finish();
  end
endmodule
